// file: core/sbrg_prescaler.sv
// Prescaler dividing the system clock by 64, 16 or 4.
// Assumes the clear input is a one-cycle pulse from the same clock.
module sbrg_prescaler (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Async reset, active high
	input wire sbrg_pkg::sbrg_scale_e scaleSel, // Multiplier choice
	input wire logic clear, // Restart from zero
	output logic tick // One pulse per prescale period
);
	import sbrg_pkg::*;

	logic [PRE_W-1:0] count_q;
	logic [PRE_W-1:0] last;

	always_comb begin
		unique case (scaleSel)
			SBRG_DIV64: last = PRE_LAST_64;
			SBRG_DIV16: last = PRE_LAST_16;
			SBRG_DIV4: last = PRE_LAST_4;
			default: last = PRE_LAST_64;
		endcase
	end

	// Count wraps at or past the last value so a mode change cannot stall
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= '0;
		end else if (clear || count_q >= last) begin
			count_q <= '0;
		end else begin
			count_q <= count_q + 1'b1;
		end
	end

	assign tick = !clear && (count_q >= last);

endmodule

// file: core/sbrg_top.sv
// Serial baud rate generator with its AHB-Lite register slave.
// Assumes one system clock; receiver and transmitter status come
// from logic on the same clock and need no synchroniser.
//
// Contract
// - Generator is a dedicated timer counting as 8-bit or 16-bit.
// - After reset the generator counts in 8-bit mode.
// - Setting sixteen-bit select switches the generator to 16-bit.
// - Timer runs continuously; period set by divisor high:low as n.
// - Asynchronous multiplier depends on high-speed and 16-bit bits.
// - Synchronous mode ignores the high-speed select bit.
// - Divide by 64(n+1) 8-bit async low, 16(n+1) if one of 16-bit or high-speed set, 4(n+1) both or sync.
// - Any divisor write clears the generator counter at once.
// - Sixteen-bit select one means 16-bit, zero means 8-bit.
// - Mode-select one means synchronous, zero asynchronous.
// - Receiver idle flag set while idle, cleared while receiving.
module sbrg_top #(
	parameter int unsigned COUNT_W = 16 // Generator counter width
) (
	input wire logic clk, // System clock, 100 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	output logic [31:0] hrdata, // AHB read data
	input wire logic rxBusy, // Receiver has a start bit in hand
	input wire logic txShiftEmpty, // Transmit shift register empty
	input wire logic [2:0] rxStatus, // Receiver error and ninth bit
	input wire logic autoBaudOvf, // Auto-baud timer overflow
	output logic baudTick, // One pulse per baud period
	output logic syncMode, // Synchronous mode selected
	output logic [7:0] baudControl, // Baud control contents
	output logic [7:0] txControl, // Transmit control contents
	output logic [7:0] rxControl // Receive control contents
);
	import sbrg_pkg::*;

	if (COUNT_W != 16) begin : g_width_check
		$error("sbrg_top supports only a 16-bit generator");
	end

	// Bus state
	logic addrValid;
	logic wrPend_q;
	logic [7:0] wrAddr_q;
	logic [31:0] rdData_q;
	logic [31:0] rdNext;
	logic [7:0] rdAddr;

	// Registers
	logic [7:0] baudCtrl_q;
	logic [7:0] txCtrl_q;
	logic [7:0] rxCtrl_q;
	logic [7:0] divLow_q;
	logic [7:0] divHigh_q;
	logic rxIdle_q;

	// Generator state
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] periodN;
	logic sixteenBit;
	logic highSpeed;
	logic divWrite;
	logic preTick;
	logic wrapNow;
	logic baudTick_q;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_q;

	assign addrValid = hsel && hready && htrans[1];
	assign rdAddr = haddr[7:0];

	// Address phase of a write is held for its data phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPend_q <= 1'b0;
		end else begin
			wrPend_q <= addrValid && hwrite;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrAddr_q <= 8'h00;
		end else if (addrValid && hwrite) begin
			wrAddr_q <= haddr[7:0];
		end
	end

	// Read data is sampled in the address phase, shown in the data phase
	always_comb begin
		rdNext = 32'h0000_0000;
		unique case (rdAddr)
			ADDR_BAUD_CTRL: rdNext[7:0] = baudControl;
			ADDR_RX_CTRL: rdNext[7:0] = rxControl;
			ADDR_DIV_LOW: rdNext[7:0] = divLow_q;
			ADDR_DIV_HIGH: rdNext[7:0] = divHigh_q;
			ADDR_TX_CTRL: rdNext[7:0] = txControl;
			ADDR_COUNT: rdNext[COUNT_W-1:0] = count_q;
			default: rdNext = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_q <= 32'h0000_0000;
		end else if (addrValid && !hwrite) begin
			rdData_q <= rdNext;
		end
	end

	// Baud control: only select, polarity, wake and auto-baud are writable
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			baudCtrl_q <= BC_RESET;
		end else if (wrPend_q && wrAddr_q == ADDR_BAUD_CTRL) begin
			baudCtrl_q <= hwdata[7:0] & BC_WR_MASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			txCtrl_q <= TS_RESET;
		end else if (wrPend_q && wrAddr_q == ADDR_TX_CTRL) begin
			txCtrl_q <= hwdata[7:0] & TS_WR_MASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxCtrl_q <= RS_RESET;
		end else if (wrPend_q && wrAddr_q == ADDR_RX_CTRL) begin
			rxCtrl_q <= hwdata[7:0] & RS_WR_MASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divLow_q <= DIV_RESET;
		end else if (wrPend_q && wrAddr_q == ADDR_DIV_LOW) begin
			divLow_q <= hwdata[7:0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divHigh_q <= DIV_RESET;
		end else if (wrPend_q && wrAddr_q == ADDR_DIV_HIGH) begin
			divHigh_q <= hwdata[7:0];
		end
	end

	// Idle flag follows the receiver one cycle later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxIdle_q <= RX_IDLE_RESET;
		end else begin
			rxIdle_q <= !rxBusy;
		end
	end

	// Read views merge stored bits with live status
	always_comb begin
		baudControl = baudCtrl_q;
		baudControl[BC_ABD_OVF] = autoBaudOvf;
		baudControl[BC_RX_IDLE] = rxIdle_q;
	end

	always_comb begin
		txControl = txCtrl_q;
		txControl[TS_SHIFT_EMPTY] = txShiftEmpty;
	end

	always_comb begin
		rxControl = rxCtrl_q;
		rxControl[2:0] = rxStatus;
	end

	// Mode decode
	assign syncMode = txCtrl_q[TS_SYNC];
	assign sixteenBit = baudCtrl_q[BC_SIXTEEN];
	assign highSpeed = txCtrl_q[TS_HIGH_SPEED] && !syncMode;

	sbrg_scale_e scaleSel;

	always_comb begin
		if (syncMode) begin
			scaleSel = SBRG_DIV4;
		end else if (sixteenBit && highSpeed) begin
			scaleSel = SBRG_DIV4;
		end else if (sixteenBit || highSpeed) begin
			scaleSel = SBRG_DIV16;
		end else begin
			scaleSel = SBRG_DIV64;
		end
	end

	// Period value n: full pair in 16-bit mode, low byte only in 8-bit
	always_comb begin
		if (sixteenBit) begin
			periodN = {divHigh_q, divLow_q};
		end else begin
			periodN = {8'h00, divLow_q};
		end
	end

	// Either divisor write restarts prescaler and counter together
	assign divWrite = wrPend_q &&
		(wrAddr_q == ADDR_DIV_LOW || wrAddr_q == ADDR_DIV_HIGH);

	sbrg_prescaler u_prescaler (
		.clk(clk),
		.sys_rst(sys_rst),
		.scaleSel(scaleSel),
		.clear(divWrite),
		.tick(preTick)
	);

	// Counter wraps at n, or past it if n shrank under it
	assign wrapNow = preTick && (count_q >= periodN);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= '0;
		end else if (divWrite) begin
			count_q <= '0;
		end else if (wrapNow) begin
			count_q <= '0;
		end else if (preTick) begin
			count_q <= count_q + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			baudTick_q <= 1'b0;
		end else begin
			baudTick_q <= wrapNow && !divWrite;
		end
	end

	assign baudTick = baudTick_q;

endmodule

// file: shared/sbrg_pkg.sv
// Constants for the serial baud rate generator block.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package sbrg_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_BAUD_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
	localparam logic [7:0] ADDR_DIV_LOW = 8'h08;
	localparam logic [7:0] ADDR_DIV_HIGH = 8'h0C;
	localparam logic [7:0] ADDR_TX_CTRL = 8'h10;
	localparam logic [7:0] ADDR_COUNT = 8'h14;

	// Baud control fields
	localparam int unsigned BC_ABD_OVF = 7;
	localparam int unsigned BC_RX_IDLE = 6;
	localparam int unsigned BC_CLK_POL = 4;
	localparam int unsigned BC_SIXTEEN = 3;
	localparam int unsigned BC_WAKE = 1;
	localparam int unsigned BC_ABD_EN = 0;
	localparam logic [7:0] BC_WR_MASK = 8'h1B;

	// Transmit status and control fields
	localparam int unsigned TS_CLK_SRC = 7;
	localparam int unsigned TS_SYNC = 4;
	localparam int unsigned TS_HIGH_SPEED = 2;
	localparam int unsigned TS_SHIFT_EMPTY = 1;
	localparam logic [7:0] TS_WR_MASK = 8'hFD;

	// Receive status and control fields
	localparam int unsigned RS_PORT_EN = 7;
	localparam logic [7:0] RS_WR_MASK = 8'hF8;

	// Values after reset
	localparam logic [7:0] BC_RESET = 8'h00;
	localparam logic [7:0] TS_RESET = 8'h00;
	localparam logic [7:0] RS_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h00;
	localparam logic RX_IDLE_RESET = 1'b1;

	// Prescale multipliers as last prescaler counts
	localparam int unsigned PRE_W = 6;
	localparam logic [5:0] PRE_LAST_64 = 6'h3F;
	localparam logic [5:0] PRE_LAST_16 = 6'h0F;
	localparam logic [5:0] PRE_LAST_4 = 6'h03;

	typedef enum logic [2:0] {
		SBRG_DIV64 = 3'b001,
		SBRG_DIV16 = 3'b010,
		SBRG_DIV4 = 3'b100
	} sbrg_scale_e;

endpackage

// file: test/sbrg_checker.sv
// Port checks for the baud rate generator top.
// Assumes one clock; attached to sbrg_top by the bind below.
module sbrg_checker
	import sbrg_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	input wire logic rxBusy, // Receiver busy
	input wire logic baudTick, // Baud pulse
	input wire logic syncMode, // Sync mode
	input wire logic [7:0] baudControl, // Baud control view
	input wire logic [7:0] txControl // Transmit control view
);
	logic [7:0] wrAddr_q, divLo_q, divHi_q;
	logic clean_q, divWr;
	logic modeSync_q, modeHigh_q, modeWide_q;
	int unsigned gap_q, expGap;
	assign divWr = wrAddr_q == ADDR_DIV_LOW || wrAddr_q == ADDR_DIV_HIGH;
	// Data-phase write address, 8'hFF when none
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) wrAddr_q <= 8'hFF;
		else if (hsel && hready && htrans[1] && hwrite) wrAddr_q <= haddr[7:0];
		else wrAddr_q <= 8'hFF;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			divLo_q <= DIV_RESET;
			divHi_q <= DIV_RESET;
		end else if (wrAddr_q == ADDR_DIV_LOW) divLo_q <= hwdata[7:0];
		else if (wrAddr_q == ADDR_DIV_HIGH) divHi_q <= hwdata[7:0];
	end
	// Mode bits as software wrote them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeSync_q <= TS_RESET[TS_SYNC];
			modeHigh_q <= TS_RESET[TS_HIGH_SPEED];
		end else if (wrAddr_q == ADDR_TX_CTRL) begin
			modeSync_q <= hwdata[TS_SYNC];
			modeHigh_q <= hwdata[TS_HIGH_SPEED];
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			modeWide_q <= BC_RESET[BC_SIXTEEN];
		end else if (wrAddr_q == ADDR_BAUD_CTRL) begin
			modeWide_q <= hwdata[BC_SIXTEEN];
		end
	end
	// Period is judged only when no write fell inside it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) clean_q <= 1'b0;
		else if (wrAddr_q != 8'hFF) clean_q <= 1'b0;
		else if (baudTick) clean_q <= 1'b1;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) gap_q <= 0;
		else if (baudTick || divWr) gap_q <= 1;
		else gap_q <= gap_q + 1;
	end
	always_comb begin
		expGap = (modeSync_q || (modeWide_q && modeHigh_q))
			? 4 : (modeWide_q || modeHigh_q) ? 16 : 64;
		expGap = expGap * (modeWide_q ?
			int'({divHi_q, divLo_q}) + 1 : int'(divLo_q) + 1);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_period_exact: assert property (
		baudTick && clean_q |-> gap_q == expGap) else $error("bad period");
	chk_free_running: assert property (
		gap_q <= 4194305) else $error("generator stopped");
	chk_tick_spacing: assert property (
		baudTick |=> !baudTick [*3]) else $error("ticks too close");
	chk_div_restart: assert property (
		divWr |=> ##1 !baudTick [*3]) else $error("no restart");
	chk_idle_clear: assert property (
		rxBusy |=> !baudControl[BC_RX_IDLE]) else $error("idle kept");
	chk_idle_set: assert property (
		!rxBusy |=> baudControl[BC_RX_IDLE]) else $error("idle missing");
	chk_sync_view: assert property (
		syncMode == modeSync_q) else $error("sync view");
	chk_eight_hold: assert property (
		!baudControl[BC_SIXTEEN] && wrAddr_q != ADDR_BAUD_CTRL
		|=> !baudControl[BC_SIXTEEN]) else $error("mode moved");
	chk_width_select: assert property (
		wrAddr_q == ADDR_BAUD_CTRL |=> baudControl[BC_SIXTEEN] ==
		$past(hwdata[BC_SIXTEEN])) else $error("width select");
	cov_sync_tick: cover property (baudTick && syncMode);
	cov_wide_tick: cover property (baudTick && baudControl[BC_SIXTEEN]);
	cov_restart: cover property (divWr);
endmodule
bind sbrg_top sbrg_checker sbrg_checker_inst (.clk, .sys_rst, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .rxBusy, .baudTick,
	.syncMode, .baudControl, .txControl);

// file: test/test_sbrg_top.sv
// Self-checking bench for the baud rate generator block.
// Assumes zero-wait bus answers and one 100 MHz clock.
module test_sbrg_top import sbrg_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic rxBusy = 1'b0;
	logic txShiftEmpty = 1'b1;
	logic autoBaudOvf = 1'b0;
	logic [2:0] rxStatus = 3'b000;
	logic hreadyout, hresp, baudTick, syncMode;
	logic [31:0] hrdata;
	logic [7:0] baudControl, txControl, rxControl;
	int nErrors = 0;
	int cmpCount = 0;
	int cyc = 0;
	sbrg_top sbrg_top_inst (.clk, .sys_rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .rxBusy, .txShiftEmpty, .rxStatus, .autoBaudOvf,
		.baudTick, .syncMode, .baudControl, .txControl, .rxControl);
	always #5 clk = ~clk;
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			nErrors++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer, entered at a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0000_0000, r);
		check(r, exp);
	endtask
	task automatic waitTick(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while (baudTick !== 1'b1 && c < 5000);
	endtask
	function automatic int period(input logic s, b, h,
		input logic [7:0] lo, hi);
		int m;
		m = (s || (b && h)) ? 4 : (b || h) ? 16 : 64;
		return m * (b ? int'({hi, lo}) + 1 : int'(lo) + 1);
	endfunction
	initial begin
		logic [31:0] d;
		logic [7:0] lo, hi;
		logic [2:0] cfg;
		int c, p;
		void'($urandom(32'hbc68));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rdchk(ADDR_BAUD_CTRL, 32'h0000_0040);
		rdchk(ADDR_TX_CTRL, 32'h0000_0002);
		rdchk(ADDR_DIV_LOW, 32'h0000_0000);
		rdchk(ADDR_DIV_HIGH, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			rxBusy <= i[0];
			autoBaudOvf <= 1'($urandom);
			txShiftEmpty <= 1'($urandom);
			rxStatus <= 3'($urandom);
			d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			wr(ADDR_BAUD_CTRL, d);
			wr(8'h18, d);
			rdchk(ADDR_BAUD_CTRL, {autoBaudOvf, !rxBusy, 6'b00_0000}
				| (d[7:0] & BC_WR_MASK));
			wr(ADDR_TX_CTRL, d);
			rdchk(ADDR_TX_CTRL, {txShiftEmpty, 1'b0}
				| (d[7:0] & TS_WR_MASK));
			wr(ADDR_RX_CTRL, d);
			rdchk(ADDR_RX_CTRL, rxStatus | (d[7:0] & RS_WR_MASK));
			rdchk(8'h18, 32'h0000_0000);
		end
		$display("test registers done");
		rxBusy <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			cfg = 3'(k);
			lo = (k == 0) ? 8'h00 : (k == 5) ? 8'hFF : 8'($urandom_range(15));
			hi = (k == 0) ? 8'h01 : 8'($urandom_range(1));
			p = period(cfg[2], cfg[1], cfg[0], lo, hi);
			wr(ADDR_TX_CTRL, (32'(cfg[2]) << TS_SYNC)
				| (32'(cfg[0]) << TS_HIGH_SPEED));
			wr(ADDR_BAUD_CTRL, 32'(cfg[1]) << BC_SIXTEEN);
			wr(ADDR_DIV_HIGH, 32'(hi));
			wr(ADDR_DIV_LOW, 32'(lo));
			waitTick(c);
			check(c, p);
			waitTick(c);
			check(c, p);
			@(posedge clk);
			rdchk(ADDR_DIV_HIGH, 32'(hi));
		end
		$display("test periods done");
		conclude();
	end
endmodule
